// File: snoop_data_intervention.sv
`timescale 1ns/1ps
module snoop_data_intervention
   import snoop_intervention_pkg::*;
#(
   parameter int QDEPTH = QUEUE_DEPTH,
   parameter int FDEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                mclk_i,
   input  wire logic                rst_n_i,
   // Static configuration
   input  wire logic                intervention_disable_i,
   input  wire logic                split_transaction_bus_mode_i,
   // Snooped address tenure
   input  wire logic                transfer_start_i,
   input  wire snoop_type_t         snoop_type_i,
   input  wire logic [DW_W-1:0]     snoop_dw_i,
   input  wire logic                write_through_attr_i,
   input  wire logic                cache_inhibit_attr_i,
   input  wire logic                line_modified_i,
   input  wire logic                snoop_resp_next_i,
   input  wire logic                address_retry_i,
   // Cache line fetch into the intervention buffer
   output logic                     fetch_req_o,
   output logic [DW_W-1:0]          fetch_dw_o,
   input  wire logic                fill_valid_i,
   input  wire logic [DATA_W-1:0]   fill_data_i,
   output logic                     fill_ready_o,
   // Data bus side
   input  wire logic                data_bus_grant_i,
   input  wire logic                transfer_acknowledge_i,
   output logic                     hit_o,
   output logic                     data_only_request_strobe_o,
   output logic [DATA_W-1:0]        data_o,
   output logic [DW_W-1:0]          data_dw_o,
   output logic                     data_oe_o,
   // Status
   output logic [CNT_W-1:0]         outstanding_o,
   output logic                     queue_full_o
);

   // Bus inputs are synchronous to mclk_i; only the disable and mode pins are synchronised
   logic        dis_meta_q;
   logic        dis_sync_q;
   logic        mode_meta_q;
   logic        mode_sync_q;

   // Snoop tracking
   logic            pend_valid_q;
   logic            pend_elig_q;
   logic [DW_W-1:0] pend_dw_q;
   logic            hit_q;
   logic            hit_d;
   logic [DW_W-1:0] hit_dw_q;
   logic            read_type;
   logic            snoop_elig;
   logic            append;

   // Queue of critical double-words awaiting fetch, in hit order
   logic [DW_W-1:0]  dw_mem [QDEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] fetch_cnt_q;
   logic             fetch_go;
   logic             fetch_busy_q;
   logic             fetch_req_q;
   logic [DW_W-1:0]  fetch_dw_q;
   logic [DW_W-1:0]  line_dw_q;

   // Fill accounting
   logic [1:0]       fill_beat_q;
   logic             fill_push;
   logic             line_done;

   // Strobe and grant accounting
   logic [CNT_W-1:0] outst_cnt_q;
   logic [CNT_W-1:0] ready_cnt_q;
   logic [CNT_W-1:0] await_cnt_q;
   logic             data_only_request_strobe_fire;
   logic             data_only_request_strobe_q;
   logic             grant_take;

   // Data push
   push_state_t         state_q;
   logic [1:0]          push_beat_q;
   logic [DATA_W-1:0]   data_q;
   logic [DW_W-1:0]     data_dw_q;
   logic                data_oe_q;
   logic                pop;

   line_fifo_if #(.WIDTH(DATA_W + DW_W)) buf_if ();

   line_fifo #(
      .WIDTH (DATA_W + DW_W),
      .DEPTH (FDEPTH)
   ) u_buf (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .fifo    (buf_if.store)
   );

   // Two-stage synchronisers for the static control pins
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dis_meta_q  <= 1'b1;
         dis_sync_q  <= 1'b1;
         mode_meta_q <= 1'b0;
         mode_sync_q <= 1'b0;
      end else begin
         dis_meta_q  <= intervention_disable_i;
         dis_sync_q  <= dis_meta_q;
         mode_meta_q <= split_transaction_bus_mode_i;
         mode_sync_q <= mode_meta_q;
      end
   end

   // Attribute inputs are deliberately not looked at: any read-type snoop may hit
   assign read_type = (snoop_type_i == SNP_READ) ||
                      (snoop_type_i == SNP_READ_WITH_INTENT_TO_MODIFY) ||
                      (snoop_type_i == SNP_READ_CLAIM);

   // Only modified lines are ever supplied; clean and flush push regardless of disable
   assign snoop_elig = line_modified_i && mode_sync_q &&
                       ((read_type && !dis_sync_q) ||
                        (snoop_type_i == SNP_CLEAN) ||
                        (snoop_type_i == SNP_FLUSH));

   // Hit only while a queue slot remains, counting a hit still in its window
   assign hit_d = snoop_resp_next_i && pend_valid_q && pend_elig_q &&
                  ((outst_cnt_q + CNT_W'(hit_q)) < CNT_W'(QDEPTH));

   // A hit that meets a retry in its window is dropped, never queued
   assign append = hit_q && !address_retry_i;

   // Catch the snoop at its start and hold the decision until its window
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_valid_q <= 1'b0;
         pend_elig_q  <= 1'b0;
         pend_dw_q    <= DW_RST;
      end else if (transfer_start_i) begin
         pend_valid_q <= 1'b1;
         pend_elig_q  <= snoop_elig;
         pend_dw_q    <= snoop_dw_i;
      end else if (snoop_resp_next_i) begin
         pend_valid_q <= 1'b0;
      end
   end

   // Hit response, driven during the response window only
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hit_q    <= 1'b0;
         hit_dw_q <= DW_RST;
      end else begin
         hit_q    <= hit_d;
         hit_dw_q <= pend_dw_q;
      end
   end

   // Critical double-word of each appended line, kept in hit order
   always_ff @(posedge mclk_i) begin
      if (append) begin
         dw_mem[wr_ptr_q] <= hit_dw_q;
      end
   end

   // One line fetch at a time; the buffer fills in the order hits were given
   assign fetch_go = (fetch_cnt_q != CNT_RST) && !fetch_busy_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q    <= PTR_RST;
         rd_ptr_q    <= PTR_RST;
         fetch_cnt_q <= CNT_RST;
      end else begin
         if (append) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (fetch_go) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         fetch_cnt_q <= fetch_cnt_q + CNT_W'(append) - CNT_W'(fetch_go);
      end
   end

   // Fetch request pulse carries the starting double-word so beats wrap from it
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fetch_req_q  <= 1'b0;
         fetch_dw_q   <= DW_RST;
         fetch_busy_q <= 1'b0;
      end else begin
         fetch_req_q <= fetch_go;
         if (fetch_go) begin
            fetch_dw_q   <= dw_mem[rd_ptr_q];
            fetch_busy_q <= 1'b1;
         end else if (line_done) begin
            fetch_busy_q <= 1'b0;
         end
      end
   end

   // Beats enter the buffer tagged with their double-word index
   assign fill_push = fill_valid_i && buf_if.push_ready;
   assign line_done = fill_push && (fill_beat_q == BEAT_LAST);
   assign buf_if.push_valid = fill_valid_i;
   assign buf_if.push_data  = {fill_beat_q + fetch_dw_q, fill_data_i};

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fill_beat_q <= 2'h0;
      end else if (fill_push) begin
         fill_beat_q <= fill_beat_q + 2'h1;
      end
   end

   // Strobe only once a whole line sits in the buffer, never beside a hit or just after one
   assign data_only_request_strobe_fire = (ready_cnt_q != CNT_RST) && !hit_d && !hit_q;

   // Lines waiting for their strobe; one strobe per line, back to back if several wait
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_cnt_q <= CNT_RST;
         data_only_request_strobe_q      <= 1'b0;
      end else begin
         ready_cnt_q <= ready_cnt_q + CNT_W'(line_done) - CNT_W'(data_only_request_strobe_fire);
         data_only_request_strobe_q      <= data_only_request_strobe_fire;
      end
   end

   // A grant only counts once a strobe for the oldest line has gone out
   assign grant_take = data_bus_grant_i && (await_cnt_q != CNT_RST) &&
                       (state_q == PUSH_IDLE);

   // Strobed lines awaiting grant, and total outstanding entries
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         await_cnt_q <= CNT_RST;
         outst_cnt_q <= CNT_RST;
      end else begin
         await_cnt_q <= await_cnt_q + CNT_W'(data_only_request_strobe_fire) - CNT_W'(grant_take);
         outst_cnt_q <= outst_cnt_q + CNT_W'(append) - CNT_W'(grant_take);
      end
   end

   // Pop on the grant for the first beat and on each acknowledge but the last
   assign pop = grant_take ||
                ((state_q == PUSH_BEAT) && transfer_acknowledge_i && (push_beat_q != BEAT_LAST));
   assign buf_if.pop_ready = pop;

   // Data tenure: no address phase of its own, just beats paced by acknowledge
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q     <= PUSH_IDLE;
         push_beat_q <= 2'h0;
         data_q      <= '0;
         data_dw_q   <= DW_RST;
         data_oe_q   <= 1'b0;
      end else begin
         case (state_q)
            PUSH_IDLE: begin
               if (grant_take) begin
                  state_q     <= PUSH_BEAT;
                  push_beat_q <= 2'h0;
                  data_q      <= buf_if.pop_data[DATA_W-1:0];
                  data_dw_q   <= buf_if.pop_data[DATA_W+DW_W-1:DATA_W];
                  data_oe_q   <= 1'b1;
               end
            end
            PUSH_BEAT: begin
               if (transfer_acknowledge_i) begin
                  if (push_beat_q == BEAT_LAST) begin
                     state_q   <= PUSH_IDLE;
                     data_oe_q <= 1'b0;
                  end else begin
                     push_beat_q <= push_beat_q + 2'h1;
                     data_q      <= buf_if.pop_data[DATA_W-1:0];
                     data_dw_q   <= buf_if.pop_data[DATA_W+DW_W-1:DATA_W];
                  end
               end
            end
            default: begin
               state_q   <= PUSH_IDLE;
               data_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // Status flags registered for clean outputs
   logic queue_full_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         queue_full_q <= 1'b0;
      end else begin
         queue_full_q <= (outst_cnt_q >= CNT_W'(QDEPTH));
      end
   end

   // Outputs; fill_ready_o is the buffer's own registered ready, so the cache stalls on it
   assign hit_o                      = hit_q;
   assign data_only_request_strobe_o = data_only_request_strobe_q;
   assign fetch_req_o                = fetch_req_q;
   assign fetch_dw_o                 = fetch_dw_q;
   assign fill_ready_o               = buf_if.push_ready;
   assign data_o                     = data_q;
   assign data_dw_o                  = data_dw_q;
   assign data_oe_o                  = data_oe_q;
   assign outstanding_o              = outst_cnt_q;
   assign queue_full_o               = queue_full_q;

endmodule : snoop_data_intervention

// File: snoop_intervention_pkg.sv
package snoop_intervention_pkg;

   // Bus data and line geometry
   localparam int DATA_W      = 64;
   localparam int DW_W        = 2;
   localparam int LINE_BEATS  = 4;
   localparam logic [1:0] BEAT_LAST = 2'h3;

   // Outstanding data-only queue and intervention buffer sizes
   localparam int QUEUE_DEPTH = 16;
   localparam int FIFO_DEPTH  = 32;
   localparam int PTR_W       = 4;
   localparam int CNT_W       = 5;

   // Reset values
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
   localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
   localparam logic [1:0]       DW_RST  = 2'h0;

   // Snooped transaction kinds as decoded from the transfer type
   typedef enum logic [2:0] {
      SNP_READ        = 3'h0,
      SNP_READ_WITH_INTENT_TO_MODIFY       = 3'h1,
      SNP_READ_CLAIM      = 3'h2,
      SNP_CLEAN       = 3'h3,
      SNP_FLUSH       = 3'h4,
      SNP_WRITE_FLUSH = 3'h5,
      SNP_OTHER       = 3'h6
   } snoop_type_t;

   // Data tenure push machine
   typedef enum logic [1:0] {
      PUSH_IDLE = 2'b01,
      PUSH_BEAT = 2'b10
   } push_state_t;

endpackage : snoop_intervention_pkg

// File: line_fifo_if.sv
`timescale 1ns/1ps
interface line_fifo_if #(
   parameter int WIDTH = 8
);
   logic             push_valid;
   logic             push_ready;
   logic [WIDTH-1:0] push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [WIDTH-1:0] pop_data;

   // The buffer itself
   modport store (
      input  push_valid,
      input  push_data,
      input  pop_ready,
      output push_ready,
      output pop_valid,
      output pop_data
   );

   // The logic that fills and drains it
   modport user (
      output push_valid,
      output push_data,
      output pop_ready,
      input  push_ready,
      input  pop_valid,
      input  pop_data
   );
endinterface : line_fifo_if

// File: line_fifo.sv
`timescale 1ns/1ps
module line_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic    mclk_i,
   input  wire logic    rst_n_i,
   // Both ends of the buffer
   line_fifo_if.store   fifo
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic [AW:0]      count_d;
   logic             ready_q;
   logic             valid_q;
   logic             do_push;
   logic             do_pop;

   // Handshakes; flags are registered so ports never see a combinational path
   assign do_push = fifo.push_valid && ready_q;
   assign do_pop  = fifo.pop_ready && valid_q;
   assign fifo.push_ready = ready_q;
   assign fifo.pop_valid  = valid_q;
   assign fifo.pop_data   = mem[rd_ptr_q];

   // Occupancy after this edge
   always_comb begin
      count_d = count_q;
      if (do_push && !do_pop) begin
         count_d = count_q + 1'b1;
      end else if (do_pop && !do_push) begin
         count_d = count_q - 1'b1;
      end
   end

   // Storage array, written only on an accepted push
   always_ff @(posedge mclk_i) begin
      if (do_push) begin
         mem[wr_ptr_q] <= fifo.push_data;
      end
   end

   // Pointers and honest full / empty flags
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
         ready_q  <= 1'b0;
         valid_q  <= 1'b0;
      end else begin
         if (do_push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_d;
         ready_q <= (count_d != (AW + 1)'(DEPTH));
         valid_q <= (count_d != '0);
      end
   end

endmodule : line_fifo

// File: snoop_data_intervention_properties.sv
`timescale 1ns/1ps
module snoop_data_intervention_properties
   import snoop_intervention_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   // Snoop side
   input  wire logic              intervention_disable_i,
   input  wire logic              transfer_start_i,
   input  wire snoop_type_t       snoop_type_i,
   input  wire logic              line_modified_i,
   input  wire logic              snoop_resp_next_i,
   input  wire logic              address_retry_i,
   // Data bus side
   input  wire logic              transfer_acknowledge_i,
   input  wire logic              hit_o,
   input  wire logic              data_only_request_strobe_o,
   input  wire logic [DATA_W-1:0] data_o,
   input  wire logic [DW_W-1:0]   data_dw_o,
   input  wire logic              data_oe_o,
   input  wire logic [CNT_W-1:0]  outstanding_o
);
   snoop_type_t typ_q;
   logic        mod_q;

   // Keep the snooped kind until its window decides, since the pins move on
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         typ_q <= SNP_OTHER;
         mod_q <= 1'b0;
      end else if (transfer_start_i) begin
         typ_q <= snoop_type_i;
         mod_q <= line_modified_i;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   hit_window_a: assert property (hit_o |-> $past(snoop_resp_next_i))
      else $error("hit outside response window");
   hit_cause_a: assert property (hit_o |-> mod_q && typ_q != SNP_WRITE_FLUSH
      && typ_q != SNP_OTHER)
      else $error("hit without modified line or on write flush");
   hit_disabled_a: assert property (hit_o && typ_q inside {SNP_READ, SNP_READ_WITH_INTENT_TO_MODIFY, SNP_READ_CLAIM}
      |-> !($past(intervention_disable_i, 2) && $past(intervention_disable_i, 3) && $past(intervention_disable_i, 4)))
      else $error("read hit while intervention disabled");
   hit_room_a: assert property (hit_o |-> outstanding_o < 5'h10)
      else $error("hit with queue full");
   strobe_apart_a: assert property (data_only_request_strobe_o |-> !hit_o)
      else $error("strobe with hit");
   strobe_after_a: assert property (hit_o |=> !data_only_request_strobe_o)
      else $error("strobe right after hit");
   strobe_owed_a: assert property (data_only_request_strobe_o |-> outstanding_o != CNT_RST)
      else $error("strobe with nothing queued");
   hit_append_a: assert property (hit_o && !address_retry_i && outstanding_o == CNT_RST
      |=> outstanding_o == 5'h01)
      else $error("hit not queued");
   retry_drop_a: assert property (hit_o && address_retry_i && outstanding_o == CNT_RST
      |=> outstanding_o == CNT_RST)
      else $error("retried hit queued");
   beat_order_a: assert property (data_oe_o && transfer_acknowledge_i ##1 data_oe_o
      |-> data_dw_o == $past(data_dw_o) + 2'h1 && $changed(data_o))
      else $error("beat out of order");
endmodule : snoop_data_intervention_properties

bind snoop_data_intervention snoop_data_intervention_properties u_props (
   .mclk_i, .rst_n_i, .intervention_disable_i, .transfer_start_i, .snoop_type_i, .line_modified_i,
   .snoop_resp_next_i, .address_retry_i, .transfer_acknowledge_i, .hit_o, .data_only_request_strobe_o,
   .data_o, .data_dw_o, .data_oe_o, .outstanding_o
);

// File: bus_arbiter_model.sv
`timescale 1ns/1ps
module bus_arbiter_model (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // Behaviour controls
   input  wire logic stall_i,
   input  wire logic slow_i,
   // Data bus
   input  wire logic strobe_i,
   input  wire logic data_oe_i,
   // Snoop response seen on the bus
   input  wire logic hit_i,
   input  wire logic retry_i,
   output logic      grant_o = 1'b0,
   output logic      ack_o = 1'b0
);
   int         pend_q = 0;
   int         owed_q = 0;
   logic       busy_q = 1'b0;
   logic [1:0] beat_q = 2'h0;
   logic       take;

   // A strobe counts only while an unretried hit still owes one, whatever the snoop does now
   assign take = strobe_i && (owed_q > 0);

   // Each counted strobe cycle owes one grant; a grant opens a four-beat tenure
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q <= 0;
         owed_q <= 0;
         busy_q <= 1'b0;
         beat_q <= 2'h0;
      end else begin
         owed_q <= owed_q + int'(hit_i && !retry_i) - int'(take);
         pend_q <= pend_q + int'(take) - int'(grant_o);
         if (grant_o)
            busy_q <= 1'b1;
         if (ack_o && data_oe_i) begin
            beat_q <= beat_q + 2'h1;
            if (beat_q == 2'h3)
               busy_q <= 1'b0;
         end
      end
   end

   // Outputs move on the falling edge; grants go out strictly oldest first
   always @(negedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         grant_o <= 1'b0;
         ack_o   <= 1'b0;
      end else begin
         grant_o <= !busy_q && pend_q > 0 && !stall_i;
         ack_o   <= busy_q && data_oe_i && !(slow_i && ack_o);
      end
   end
endmodule : bus_arbiter_model

// File: snoop_data_intervention_tb_top.sv
`timescale 1ns/1ps
module snoop_data_intervention_tb_top import snoop_intervention_pkg::*;;
   logic              mclk_i = 1'b0, rst_n_i = 1'b0, intervention_disable_i = 1'b0;
   logic              split_transaction_bus_mode_i = 1'b1, transfer_start_i = 1'b0, snoop_resp_next_i = 1'b0;
   logic              write_through_attr_i = 1'b0, cache_inhibit_attr_i = 1'b0, line_modified_i = 1'b0;
   logic              address_retry_i = 1'b0, fill_valid_i = 1'b0, stall = 1'b0, slow = 1'b0, acc = 1'b0, freq = 1'b0;
   snoop_type_t       snoop_type_i = SNP_OTHER;
   logic [1:0]        snoop_dw_i = 2'h0, fdw = 2'h0, fb = 2'h0, nb = 2'h0, fetch_dw_o, data_dw_o;
   logic [DATA_W-1:0] fill_data_i, data_o;
   logic [CNT_W-1:0]  outstanding_o;
   logic              fetch_req_o, fill_ready_o, data_bus_grant_i, transfer_acknowledge_i;
   logic              hit_o, data_only_request_strobe_o, data_oe_o, queue_full_o;
   int                fails = 0, n_compared = 0, cyc = 0, nfetch = 0, npush = 0, nstrobe = 0;
   logic [1:0]        expq[$];

   snoop_data_intervention DUT (
      .mclk_i, .rst_n_i, .intervention_disable_i, .split_transaction_bus_mode_i, .transfer_start_i,
      .snoop_type_i, .snoop_dw_i, .write_through_attr_i, .cache_inhibit_attr_i, .line_modified_i,
      .snoop_resp_next_i, .address_retry_i, .fetch_req_o, .fetch_dw_o, .fill_valid_i, .fill_data_i,
      .fill_ready_o, .data_bus_grant_i, .transfer_acknowledge_i, .hit_o, .data_only_request_strobe_o,
      .data_o, .data_dw_o, .data_oe_o, .outstanding_o, .queue_full_o
   );

   bus_arbiter_model partner (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .stall_i(stall), .slow_i(slow), .strobe_i(data_only_request_strobe_o),
      .data_oe_i(data_oe_o), .hit_i(hit_o), .retry_i(address_retry_i), .grant_o(data_bus_grant_i),
      .ack_o(transfer_acknowledge_i)
   );

   always #5 mclk_i = ~mclk_i;

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic summarize;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // Cache side: four beats wrapping from the fetch index, tagged by fetch count
   always @(posedge mclk_i) begin
      acc  <= fill_valid_i && fill_ready_o;
      freq <= fetch_req_o;
   end
   always @(negedge mclk_i) begin
      if (freq) begin
         nfetch++;
         fdw = fetch_dw_o;
         fb = 2'h0;
         fill_valid_i = 1'b1;
      end else if (acc) begin
         if (fb == 2'h3)
            fill_valid_i = 1'b0;
         fb++;
      end
   end
   assign fill_data_i = {32'(nfetch), 30'h0, fdw + fb};

   // A hang ends the run through the closing report
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize;
      end
   end

   // Beats must come line by line in hit order, critical dword first; the bench snarfs each one
   always @(posedge mclk_i) begin
      if (data_only_request_strobe_o)
         nstrobe++;
      if (data_oe_o && transfer_acknowledge_i) begin
         check("beat dword", data_dw_o, 2'(expq[0] + nb));
         check("beat data", data_o, {32'(npush + 1), 30'h0, expq[0] + nb});
         if (nb == 2'h3) begin
            void'(expq.pop_front());
            npush++;
         end
         nb++;
      end
   end

   // One snoop: start, window, response; attributes toggled since they must not matter
   task automatic snoop(input snoop_type_t t, input logic [1:0] d, input logic m, input logic r, input logic e);
      @(negedge mclk_i);
      transfer_start_i = 1'b1;
      snoop_type_i = t;
      snoop_dw_i = d;
      line_modified_i = m;
      write_through_attr_i = ~write_through_attr_i;
      cache_inhibit_attr_i = d[0];
      @(negedge mclk_i);
      transfer_start_i = 1'b0;
      snoop_resp_next_i = 1'b1;
      @(negedge mclk_i);
      snoop_resp_next_i = 1'b0;
      address_retry_i = r;
      check("hit", hit_o, e);
      if (e && !r)
         expq.push_back(d);
      @(negedge mclk_i);
      address_retry_i = 1'b0;
   endtask : snoop

   task automatic drain;
      for (int i = 0; i < 3000 && expq.size() != 0; i++)
         @(negedge mclk_i);
      repeat (4) @(negedge mclk_i);
      check("lines left", 64'(expq.size()), 0);
      check("strobes", nstrobe, npush);
      check("outstanding", outstanding_o, 0);
   endtask : drain

   task automatic t_kinds;
      snoop_type_t t;
      for (int i = 0; i < 7; i++) begin
         t = snoop_type_t'(i);
         slow = i[0];
         snoop(t, 2'(i), 1'b1, 1'b0, t != SNP_WRITE_FLUSH && t != SNP_OTHER);
      end
      snoop(SNP_READ, 2'h1, 1'b0, 1'b0, 1'b0);
      drain;
   endtask : t_kinds

   task automatic t_retry;
      snoop(SNP_READ_WITH_INTENT_TO_MODIFY, 2'h2, 1'b1, 1'b1, 1'b1);
      repeat (12) @(negedge mclk_i);
      check("retried strobe", nstrobe, npush);
      check("retried entry", outstanding_o, 0);
      snoop(SNP_FLUSH, 2'h3, 1'b1, 1'b0, 1'b1);
      drain;
   endtask : t_retry

   task automatic t_disable;
      intervention_disable_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      snoop(SNP_READ_CLAIM, 2'h0, 1'b1, 1'b0, 1'b0);
      snoop(SNP_CLEAN, 2'h1, 1'b1, 1'b0, 1'b1);
      intervention_disable_i = 1'b0;
      split_transaction_bus_mode_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      snoop(SNP_READ, 2'h2, 1'b1, 1'b0, 1'b0);
      split_transaction_bus_mode_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      drain;
   endtask : t_disable

   task automatic t_full;
      stall = 1'b1;
      for (int i = 0; i < 16; i++)
         snoop(SNP_READ, 2'(i), 1'b1, 1'b0, 1'b1);
      snoop(SNP_FLUSH, 2'h0, 1'b1, 1'b0, 1'b0);
      repeat (40) @(negedge mclk_i);
      check("queue count", outstanding_o, 5'h10);
      check("queue full", queue_full_o, 1'b1);
      check("buffer refuses", fill_ready_o, 1'b0);
      stall = 1'b0;
      drain;
   endtask : t_full

   initial begin
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      check("reset hit", hit_o, 0);
      check("reset strobe", data_only_request_strobe_o, 0);
      check("reset count", outstanding_o, 0);
      repeat (3) @(negedge mclk_i);
      t_kinds;
      t_retry;
      t_disable;
      t_full;
      summarize;
   end
endmodule : snoop_data_intervention_tb_top
